//--- hw/ssdd_decimator.sv
// Purpose: stereo one-bit to PCM decimation filter with serial output
// Assumes: modulator bits synchronous to clk, coefficient rom outside
// Notes:   one pass of the symmetric filter per word period per channel
`timescale 1ns/1ns

// Overview of operation
// - each channel delivers one bit per modulator tick, 64 per word period
// - both channels filtered in the same pass, removing out-of-band noise
// - exactly one output word per channel each word period
// - output word width 16 or 18 bits, chosen by parameter
// - symmetric fir: mirrored taps share one coefficient, linear phase
// - 4095 taps per channel, 22-bit coefficients
// - coefficient set supplied gives the required band edges and attenuation
// - single stage, no multipliers: coefficients added or subtracted
// - both channels leave on one serial output, left then right
// - history advances once per modulator tick, newest in, oldest out
// - delay is half the filter length, 32 word periods
// - a stuck modulator is reset within 5 us; output just clips
// - modulator rate made by dividing master clock by four
module ssdd_decimator #(
  parameter int OUT_W      = ssdd_pkg::DEF_OUT_W,
  parameter int LANES      = ssdd_pkg::DEF_LANES,
  parameter int FIFO_DEPTH = ssdd_pkg::DEF_FIFO_DEPTH,
  parameter int RUN_LIMIT  = ssdd_pkg::DEF_RUN_LIMIT
) (
  // clock and reset
  input wire logic                                   clk,
  input wire logic                                   reset_n,
  // modulator side
  input wire logic [ssdd_pkg::NCH-1:0]               mod_bit,
  output logic                                       mod_clk,
  output logic [ssdd_pkg::NCH-1:0]                   mod_reset,
  // coefficient rom
  output logic [ssdd_pkg::PASS_W-1:0]                coef_addr,
  input wire logic [LANES*ssdd_pkg::COEF_W-1:0]      coef_word,
  // serial output
  input wire logic                                   ser_hold,
  output logic                                       ser_data,
  output logic                                       ser_word_start,
  output logic                                       ser_channel
);
  import ssdd_pkg::*;

  localparam int PASS_CYC  = PAIRS / LANES;
  localparam int OUT_SHIFT = COEF_W - OUT_W;
  localparam int WORD_W    = OUT_W + 1;
  localparam int BCW       = $clog2(OUT_W + 1);

  generate
    if (OUT_W != 16 && OUT_W != 18) begin : g_bad_out_w
      $error("output width must be 16 or 18");
    end
    if (LANES < 1 || PASS_CYC * LANES != PAIRS || PASS_CYC > MCLK_PER_WORD) begin : g_bad_lanes
      $error("lanes must divide the tap pairs and fit a word period");
    end
    if (RUN_LIMIT < 2 || RUN_LIMIT * DIV_RATIO + 2 > UNSTABLE_MAX_CYC) begin : g_bad_run
      $error("stuck-modulator limit cannot meet the reset deadline");
    end
  endgenerate

  typedef enum logic {SER_IDLE, SER_SHIFT} ssdd_ser_type;

  //////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [HIST_AW-1:0] tap_addr(input logic [HIST_AW-1:0] b,
                                                  input int j);
    return b - HIST_AW'(j);
  endfunction : tap_addr

  // one pair of mirrored taps: both one -> +2c, both zero -> -2c, else 0
  function automatic logic signed [ACC_W-1:0] pair_term(input logic pos,
                                                        input logic neg,
                                                        input logic single,
                                                        input logic [COEF_W-1:0] c);
    logic signed [ACC_W-1:0] v;
    v = {{(ACC_W-COEF_W){c[COEF_W-1]}}, c};
    if (!single) begin
      v = v <<< 1;
    end
    if (pos) begin
      return v;
    end else if (neg) begin
      return -v;
    end
    return '0;
  endfunction : pair_term

  function automatic logic [OUT_W-1:0] sat_word(input logic signed [ACC_W-1:0] v);
    logic signed [ACC_W-1:0] s;
    logic signed [ACC_W-1:0] maxv;
    logic signed [ACC_W-1:0] minv;
    s    = v >>> OUT_SHIFT;
    maxv = $signed({{(ACC_W-OUT_W+1){1'b0}}, {(OUT_W-1){1'b1}}});
    minv = ~maxv;
    if (s > maxv) begin
      return maxv[OUT_W-1:0];
    end else if (s < minv) begin
      return minv[OUT_W-1:0];
    end
    return s[OUT_W-1:0];
  endfunction : sat_word

  //////////////////////////////////////////////////////////////////////////////
  // modulator clock divider

  logic [DIV_W-1:0] div_cnt;
  logic             sample_tick;

  assign sample_tick = (div_cnt == DIV_W'(DIV_RATIO - 1));

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      div_cnt <= '0;
      mod_clk <= 1'b0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
      mod_clk <= div_cnt[DIV_W-1];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sample history, shared write pointer

  logic [HIST_AW-1:0] wp;
  logic [OVS_W-1:0]   samp_cnt;
  logic               pass_start;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wp         <= '0;
      samp_cnt   <= '0;
      pass_start <= 1'b0;
    end else begin
      pass_start <= sample_tick && (samp_cnt == OVS_W'(OVERSAMPLE - 1));
      if (sample_tick) begin
        wp       <= wp + 1'b1;
        samp_cnt <= samp_cnt + 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pass sequencer: LANES tap pairs per channel per cycle

  logic               pass_busy;
  logic [PASS_W-1:0]  pass_idx;
  logic [HIST_AW-1:0] base;

  // base freezes the newest sample; writes during the pass only hit taps
  // whose pairs were already read in the first cycles
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pass_busy <= 1'b0;
      pass_idx  <= '0;
      base      <= '0;
    end else if (pass_start) begin
      pass_busy <= 1'b1;
      pass_idx  <= '0;
      base      <= wp;
    end else if (pass_busy) begin
      pass_idx <= pass_idx + 1'b1;
      if (pass_idx == PASS_W'(PASS_CYC - 1)) begin
        pass_busy <= 1'b0;
      end
    end
  end

  wire [LANES-1:0] tap_pos [NCH];
  wire [LANES-1:0] tap_neg [NCH];

  genvar ch;
  genvar ln;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_hist
      logic hist [HIST_DEPTH];
      always_ff @(posedge clk) begin
        if (sample_tick) begin
          hist[wp + 1'b1] <= mod_bit[ch];
        end
      end
      for (ln = 0; ln < LANES; ln++) begin : g_lane
        // tap j pairs with tap TAPS-1-j; centre pair reads one tap twice
        logic a_bit;
        logic b_bit;
        assign a_bit = hist[tap_addr(base, int'(pass_idx) * LANES + ln)];
        assign b_bit = hist[tap_addr(base, TAPS - 1 - (int'(pass_idx) * LANES + ln))];
        assign tap_pos[ch][ln] = a_bit & b_bit;
        assign tap_neg[ch][ln] = ~(a_bit | b_bit);
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // issue stage: coefficient address and tap bits registered together

  logic             stage_valid;
  logic             stage_first;
  logic             stage_last;
  logic [LANES-1:0] pos_q [NCH];
  logic [LANES-1:0] neg_q [NCH];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      coef_addr   <= '0;
      stage_valid <= 1'b0;
      stage_first <= 1'b0;
      stage_last  <= 1'b0;
      for (int c = 0; c < NCH; c++) begin
        pos_q[c] <= '0;
        neg_q[c] <= '0;
      end
    end else begin
      coef_addr   <= pass_idx;
      stage_valid <= pass_busy;
      stage_first <= pass_busy && (pass_idx == '0);
      stage_last  <= pass_busy && (pass_idx == PASS_W'(PASS_CYC - 1));
      for (int c = 0; c < NCH; c++) begin
        pos_q[c] <= tap_pos[c];
        neg_q[c] <= tap_neg[c];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // accumulate stage: adds and subtracts only

  logic signed [ACC_W-1:0] term [NCH];
  logic signed [ACC_W-1:0] acc  [NCH];
  logic [OUT_W-1:0]        word_q [NCH];

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      term[c] = '0;
      for (int l = 0; l < LANES; l++) begin
        term[c] = term[c] + pair_term(pos_q[c][l], neg_q[c][l],
                                      stage_last && (l == LANES - 1),
                                      coef_word[l*COEF_W +: COEF_W]);
      end
    end
  end

  // a step reaches the output once it has travelled half the history,
  // i.e. the filter's own 32 word periods of delay
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int c = 0; c < NCH; c++) begin
        acc[c]    <= '0;
        word_q[c] <= '0;
      end
    end else if (stage_valid) begin
      for (int c = 0; c < NCH; c++) begin
        acc[c] <= stage_first ? term[c] : acc[c] + term[c];
        if (stage_last) begin
          word_q[c] <= sat_word(acc[c] + term[c]);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // push both words, left first, into the buffer

  ssdd_word_if #(.W(WORD_W)) fifo_in ();
  ssdd_word_if #(.W(WORD_W)) fifo_out ();

  logic [NCH-1:0] push_pend;
  logic           result_ready;

  assign result_ready  = stage_valid && stage_last;
  assign fifo_in.valid = (push_pend != '0);
  assign fifo_in.data  = push_pend[0] ? {1'b0, word_q[0]} : {1'b1, word_q[1]};

  // a fresh result wins over a pending push; only a stalled reader loses words
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      push_pend <= '0;
    end else if (result_ready) begin
      push_pend <= '1;
    end else if (fifo_in.valid && fifo_in.ready) begin
      if (push_pend[0]) begin
        push_pend[0] <= 1'b0;
      end else begin
        push_pend[1] <= 1'b0;
      end
    end
  end

  ssdd_word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk     (clk),
    .reset_n (reset_n),
    .wr      (fifo_in),
    .rd      (fifo_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  // serial output, msb first, one bit per four clocks

  ssdd_ser_type       ser_state;
  logic [OUT_W-1:0]   ser_shift;
  logic [BCW-1:0]     bit_cnt;
  logic [SER_DIV_W-1:0] bit_div;
  logic               ser_load;

  assign ser_load       = (ser_state == SER_IDLE) && fifo_out.valid && !ser_hold;
  assign fifo_out.ready = ser_load;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ser_state      <= SER_IDLE;
      ser_shift      <= '0;
      bit_cnt        <= '0;
      bit_div        <= '0;
      ser_data       <= 1'b0;
      ser_word_start <= 1'b0;
      ser_channel    <= 1'b0;
    end else begin
      case (ser_state)
        SER_IDLE: begin
          ser_data       <= 1'b0;
          ser_word_start <= 1'b0;
          if (ser_load) begin
            ser_shift      <= {fifo_out.data[OUT_W-2:0], 1'b0};
            ser_data       <= fifo_out.data[OUT_W-1];
            ser_channel    <= fifo_out.data[OUT_W];
            ser_word_start <= 1'b1;
            bit_cnt        <= BCW'(OUT_W - 1);
            bit_div        <= '0;
            ser_state      <= SER_SHIFT;
          end
        end
        SER_SHIFT: begin
          bit_div <= bit_div + 1'b1;
          if (bit_div == SER_DIV_W'(SER_BIT_DIV - 1)) begin
            ser_word_start <= 1'b0;
            if (bit_cnt == '0) begin
              ser_data  <= 1'b0;
              ser_state <= SER_IDLE;
            end else begin
              ser_data  <= ser_shift[OUT_W-1];
              ser_shift <= {ser_shift[OUT_W-2:0], 1'b0};
              bit_cnt   <= bit_cnt - 1'b1;
            end
          end
        end
        default: begin
          ser_state <= SER_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // stuck-modulator watchdog: a long run of one value means instability

  logic [NCH-1:0]       last_bit;
  logic [RUN_W-1:0]     run_cnt [NCH];
  logic [MOD_RST_W-1:0] rst_cnt [NCH];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      last_bit  <= '0;
      mod_reset <= '0;
      for (int c = 0; c < NCH; c++) begin
        run_cnt[c] <= '0;
        rst_cnt[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (mod_reset[c]) begin
          run_cnt[c] <= '0;
          rst_cnt[c] <= rst_cnt[c] - 1'b1;
          if (rst_cnt[c] == MOD_RST_W'(1)) begin
            mod_reset[c] <= 1'b0;
          end
        end else if (sample_tick) begin
          last_bit[c] <= mod_bit[c];
          if (mod_bit[c] != last_bit[c]) begin
            run_cnt[c] <= '0;
          end else if (run_cnt[c] == RUN_W'(RUN_LIMIT - 2)) begin
            run_cnt[c]   <= '0;
            mod_reset[c] <= 1'b1;
            rst_cnt[c]   <= MOD_RST_W'(MOD_RST_CYC);
          end else begin
            run_cnt[c] <= run_cnt[c] + 1'b1;
          end
        end
      end
    end
  end
endmodule : ssdd_decimator

//--- hw/ssdd_word_fifo.sv
// Purpose: word buffer between filter result and serial output
// Assumes: synchronous active-low reset, one clock
// Notes:   full and empty come from an occupancy count
`timescale 1ns/1ns
module ssdd_word_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic    clk,
  input wire logic    reset_n,
  // filling and draining sides
  ssdd_word_if.sink   wr,
  ssdd_word_if.source rd
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("fifo depth must be a power of two, at least 2");
    end
    if (WIDTH < 1) begin : g_bad_width
      $error("fifo width must be positive");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic             do_wr;
  logic             do_rd;

  assign wr.ready = (count != CW'(DEPTH));
  assign rd.valid = (count != '0);
  assign rd.data  = mem[rd_ptr];
  assign do_wr    = wr.valid && wr.ready;
  assign do_rd    = rd.valid && rd.ready;

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : ssdd_word_fifo

//--- inc/ssdd_pkg.sv
// Purpose: shared constants of the stereo one-bit decimation filter
// Assumes: master clock at 256 word periods, modulators at 64 per word
// Notes:   all timing derived from the 10 ns master clock period
package ssdd_pkg;
  localparam int CLK_PERIOD_NS    = 10;
  localparam int MCLK_PER_WORD    = 256;
  localparam int OVERSAMPLE       = 64;
  localparam int OVS_W            = 6;
  localparam int DIV_RATIO        = MCLK_PER_WORD / OVERSAMPLE;
  localparam int DIV_W            = 2;
  localparam int NCH              = 2;
  localparam int TAPS             = 4095;
  localparam int HIST_DEPTH       = 4096;
  localparam int HIST_AW          = 12;
  localparam int PAIRS            = (TAPS + 1) / 2;
  localparam int PASS_W           = 11;
  localparam int COEF_W           = 22;
  localparam int ACC_W            = 36;
  localparam int GROUP_DELAY_WORDS = (HIST_DEPTH / 2) / OVERSAMPLE;
  localparam int DEF_OUT_W        = 18;
  localparam int DEF_LANES        = 8;
  localparam int DEF_FIFO_DEPTH   = 8;
  localparam int SER_BIT_DIV      = 4;
  localparam int SER_DIV_W        = 2;
  localparam int UNSTABLE_MAX_NS  = 5;
  localparam int UNSTABLE_MAX_CYC = (UNSTABLE_MAX_NS * 1000) / CLK_PERIOD_NS;
  localparam int MOD_RST_NS       = 500;
  localparam int MOD_RST_CYC      = (MOD_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MOD_RST_W        = 8;
  localparam int DEF_RUN_LIMIT    = 12;
  localparam int RUN_W            = 8;
endpackage : ssdd_pkg

//--- inc/ssdd_word_if.sv
// Purpose: valid/ready word carrier between decimator stages
// Assumes: single clock domain
// Notes:   word is {channel, sample}
`timescale 1ns/1ns
interface ssdd_word_if #(
  parameter int W = 19
);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport source (output data, output valid, input ready);
  modport sink   (input data, input valid, output ready);
endinterface : ssdd_word_if

//--- sim/ssdd_decimator_assertions.sv
// Purpose: port-level checks of the stereo decimator
// Assumes: one clock, synchronous active-low reset
// Notes:   bound into every decimator instance
`timescale 1ns/1ns
module ssdd_decimator_assertions #(
  parameter int OUT_W = 18,
  parameter int LANES = 8
) (
  // clock and reset
  input wire logic                                clk,
  input wire logic                                reset_n,
  // modulator side
  input wire logic [ssdd_pkg::NCH-1:0]            mod_bit,
  input wire logic                                mod_clk,
  input wire logic [ssdd_pkg::NCH-1:0]            mod_reset,
  // coefficient rom
  input wire logic [ssdd_pkg::PASS_W-1:0]         coef_addr,
  input wire logic [LANES*ssdd_pkg::COEF_W-1:0]   coef_word,
  // serial output
  input wire logic                                ser_hold,
  input wire logic                                ser_data,
  input wire logic                                ser_word_start,
  input wire logic                                ser_channel
);
  import ssdd_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  logic       last_ch;
  logic [7:0] rst_run;
  always_ff @(posedge clk) begin
    if (!reset_n) last_ch <= 1'b1;
    else if ($rose(ser_word_start)) last_ch <= ser_channel;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) rst_run <= 8'h00;
    else if (mod_reset[0]) rst_run <= rst_run + 8'h01;
    else rst_run <= 8'h00;
  end
  ////////////////////////////////////////
  sequence pass_wrap;
    (coef_addr == 11'h0ff) ##1 (coef_addr == 11'h000);
  endsequence
  sequence word_head;
    ser_word_start [*4] ##1 !ser_word_start;
  endsequence
  mod_clk_rate_a: assert property ($rose(mod_clk) |=> mod_clk ##1 !mod_clk [*2] ##1 mod_clk)
    else $error("modulator clock is not master clock over four");
  coef_step_a: assert property ((coef_addr != 11'h000 && coef_addr < 11'h0ff)
    |=> coef_addr == $past(coef_addr) + 11'h001) else $error("coefficient index skipped");
  coef_range_a: assert property (coef_addr <= 11'h0ff)
    else $error("coefficient index beyond the mirrored half");
  pass_period_a: assert property (pass_wrap |-> ##255 pass_wrap)
    else $error("filter pass not once per word period");
  word_frame_a: assert property ($rose(ser_word_start) |-> word_head)
    else $error("word start marker not four clocks long");
  chan_alt_a: assert property ($rose(ser_word_start) |-> ser_channel != last_ch)
    else $error("left and right words do not alternate");
  chan_hold_a: assert property ($rose(ser_word_start) |=> $stable(ser_channel) [*8])
    else $error("channel flag moved inside a word");
  idle_gap_a: assert property ($rose(ser_word_start) |-> !$past(ser_data))
    else $error("no idle gap before a word");
  hold_gate_a: assert property (ser_hold |=> !$rose(ser_word_start))
    else $error("word started while held");
  mod_rst_len_a: assert property ($fell(mod_reset[0]) |-> rst_run == 8'(MOD_RST_CYC))
    else $error("modulator reset pulse has wrong length");
endmodule : ssdd_decimator_assertions

bind ssdd_decimator ssdd_decimator_assertions #(.OUT_W(OUT_W), .LANES(LANES)) chk_u (
  .clk(clk), .reset_n(reset_n), .mod_bit(mod_bit), .mod_clk(mod_clk),
  .mod_reset(mod_reset), .coef_addr(coef_addr), .coef_word(coef_word),
  .ser_hold(ser_hold), .ser_data(ser_data), .ser_word_start(ser_word_start),
  .ser_channel(ser_channel));

//--- sim/ssdd_mod_model.sv
// Purpose: one-bit modulator pair and coefficient rom for the decimator
// Assumes: bits change just after the falling modulator clock edge
// Notes:   left repeats 110, right 100; every tap holds one value
`timescale 1ns/1ns
module ssdd_mod_model #(
  parameter int LANES = 8
) (
  // modulator side
  input wire logic                                mod_clk,
  input wire logic [ssdd_pkg::NCH-1:0]            mod_reset,
  output logic [ssdd_pkg::NCH-1:0]                mod_bit,
  // test controls
  input wire logic [ssdd_pkg::NCH-1:0]            stuck,
  input wire logic [ssdd_pkg::COEF_W-1:0]         coef_val,
  // coefficient rom
  output logic [LANES*ssdd_pkg::COEF_W-1:0]       coef_word
);
  import ssdd_pkg::*;
  int phase [NCH] = '{default: 0};
  // period three divides the window length, so window sums ignore phase;
  // each modulator restarts only on its own reset, the other runs on
  always @(negedge mod_clk) begin
    #1;
    for (int c = 0; c < NCH; c++) begin
      phase[c] = (mod_reset[c] || phase[c] == 2) ? 0 : phase[c] + 1;
    end
  end
  always_comb begin
    mod_bit[0] = stuck[0] | (phase[0] != 2);
    mod_bit[1] = stuck[1] | (phase[1] == 0);
  end
  assign coef_word = {LANES{coef_val}};
endmodule : ssdd_mod_model

//--- sim/tb_stereo_sigma_delta_decimator.sv
// Purpose: self-checking bench of the stereo decimator
// Assumes: uniform taps, so a period-three input gives a known sum
// Notes:   words are rebuilt from the serial line and compared by channel
`timescale 1ns/1ns
module tb_stereo_sigma_delta_decimator;
  import ssdd_pkg::*;
  localparam int OUT_W     = 18;
  // patterns hold at most three equal bits, counting one left over across
  // a modulator reset, so the limit must sit above that
  localparam int RUN_LIMIT = 4;
  localparam int WORD      = 256;
  logic                        clk = 1'b0;
  logic                        reset_n;
  logic [NCH-1:0]              mod_bit;
  logic                        mod_clk;
  logic [NCH-1:0]              mod_reset;
  logic [NCH-1:0]              stuck;
  logic [PASS_W-1:0]           coef_addr;
  logic [DEF_LANES*COEF_W-1:0] coef_word;
  logic [COEF_W-1:0]           coef_val;
  logic                        ser_hold;
  logic                        ser_data;
  logic                        ser_word_start;
  logic                        ser_channel;
  logic [OUT_W:0]              words_q[$];
  logic [OUT_W-1:0]            shreg;
  logic                        rx_ch;
  int                          bit_n, ph, words_seen, w0, t, coef, seed;
  int                          miscompares, n_tests;
  int                          tbl[3] = '{512, 2048, -2048};
  always #5 clk = ~clk;
  ////////////////////////////////////////
  ssdd_decimator #(.OUT_W(OUT_W), .RUN_LIMIT(RUN_LIMIT)) dut_u (
    .clk(clk), .reset_n(reset_n), .mod_bit(mod_bit), .mod_clk(mod_clk),
    .mod_reset(mod_reset), .coef_addr(coef_addr), .coef_word(coef_word),
    .ser_hold(ser_hold), .ser_data(ser_data), .ser_word_start(ser_word_start),
    .ser_channel(ser_channel));
  ssdd_mod_model #(.LANES(DEF_LANES)) mod_u (
    .mod_clk(mod_clk), .mod_reset(mod_reset), .mod_bit(mod_bit), .stuck(stuck),
    .coef_val(coef_val), .coef_word(coef_word));
  ////////////////////////////////////////
  // serial receiver: one sample per four-clock bit, msb first
  always @(posedge clk) begin
    if (bit_n == 0) begin
      if (ser_word_start === 1'b1) begin
        shreg = {{(OUT_W-1){1'b0}}, ser_data};
        rx_ch = ser_channel;
        bit_n = 1;
        ph = 0;
      end
    end else if (++ph == 4) begin
      ph = 0;
      shreg = {shreg[OUT_W-2:0], ser_data};
      if (++bit_n == OUT_W) begin
        words_q.push_back({rx_ch, shreg});
        words_seen++;
        bit_n = 0;
      end
    end
  end
  ////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // net is +1 per period for 110, -1 for 100; 1365 periods fill the window
  function automatic logic [OUT_W-1:0] exp_word(input int net, input int c);
    int a;
    a = (net * (TAPS / 3) * c) >>> (COEF_W - OUT_W);
    if (a > 2 ** (OUT_W - 1) - 1) a = 2 ** (OUT_W - 1) - 1;
    if (a < -(2 ** (OUT_W - 1))) a = -(2 ** (OUT_W - 1));
    return a[OUT_W-1:0];
  endfunction : exp_word
  task automatic check_words(input int n, input int c);
    logic [OUT_W:0] w;
    for (int k = 0; k < n; k++) begin
      t = 0;
      while (words_q.size() == 0 && t < 2 * WORD) begin
        step(1);
        t++;
      end
      if (words_q.size() == 0) begin
        miscompares++;
        conclude();
      end
      w = words_q.pop_front();
      check(w[OUT_W-1:0], exp_word(w[OUT_W] ? -1 : 1, c));
    end
  endtask : check_words
  task automatic conclude;
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  ////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    ser_hold = 1'b0;
    stuck = '0;
    coef_val = 22'h000200;
    bit_n = 0;
    ph = 0;
    words_seen = 0;
    miscompares = 0;
    n_tests = 0;
    seed = 93;
    step(6);
    reset_n = 1'b1;
    // long settle: the whole history must hold the repeating patterns
    step(66 * WORD);
    for (int i = 0; i < 6; i++) begin
      coef = (i < 3) ? tbl[i] : $random(seed) % 32768;
      coef_val = coef[COEF_W-1:0];
      step(2 * WORD);
      words_q.delete();
      check_words(4, coef);
    end
    w0 = words_seen;
    step(8 * WORD);
    check(words_seen - w0, 32'd16);
    ser_hold = 1'b1;
    w0 = words_seen;
    step(3 * WORD);
    check(32'(words_seen - w0 <= 1), 32'h1);
    ser_hold = 1'b0;
    check_words(8, coef);
    stuck = 2'b01;
    t = 0;
    while (mod_reset[0] !== 1'b1 && t < 4 * (RUN_LIMIT + 4)) begin
      step(1);
      t++;
    end
    check(mod_reset, 2'b01);
    stuck = 2'b00;
    step(MOD_RST_CYC + 4);
    check(mod_reset, 2'b00);
    conclude();
  end
endmodule : tb_stereo_sigma_delta_decimator
